/* rtl/pg_cfg_pkg.sv */
// Package of offsets, reset values, fields and timing for the power-ok/ramp/fault config block
package pg_cfg_pkg;

  // Command codes of the configuration registers
  localparam logic [7:0] CODE_POWER_OK_DELAY = 8'hD4;
  localparam logic [7:0] CODE_STARTUP_RAMP_GAIN = 8'hD5;
  localparam logic [7:0] CODE_INDUCTANCE_SETTING = 8'hD6;
  localparam logic [7:0] CODE_CAPTURE_FAULT_MASK = 8'hD7;
  localparam logic [7:0] CODE_VOLTAGE_FAULT_CONFIG = 8'hD8;

  // Values after reset
  localparam logic [15:0] RST_POWER_OK_DELAY = 16'hBA00;
  localparam logic [7:0] RST_STARTUP_RAMP_GAIN = 8'h03;
  localparam logic [15:0] RST_INDUCTANCE_SETTING = 16'hB133;
  localparam logic [15:0] RST_CAPTURE_FAULT_MASK = 16'h0000;
  localparam logic [7:0] RST_VOLTAGE_FAULT_CONFIG = 8'h00;

  // Implemented bits; the rest read as zero
  localparam logic [15:0] CFM_USED_BITS = 16'h3CFF;
  localparam logic [7:0] VFC_USED_BITS = 8'h8F;

  // Capture mask bit positions
  localparam int CFM_OUT_OV_BIT = 0;
  localparam int CFM_OUT_UV_BIT = 1;

  // Voltage fault config fields
  localparam int VFC_LOW_SIDE_BIT = 7;
  localparam int VFC_COUNT_LSB = 0;
  localparam int VFC_COUNT_W = 4;

  // Linear-11 fields
  localparam int LIN_EXP_LSB = 11;
  localparam int LIN_EXP_W = 5;
  localparam int LIN_MANT_W = 11;

  // Phases-in-rail field value at and above which multiphase ramp applies
  localparam logic [2:0] PHASES_MULTI_MIN = 3'h3;

  // Fixed factor of the turn-on ramp slope
  localparam logic [3:0] RAMP_SLOPE_FACTOR = 4'hE;

  // Power-ok delay timing
  localparam int PG_TICK_NS = 125;
  localparam int PG_DELAY_MAX_MS = 500;
  localparam int NS_PER_MS = 1000000;
  localparam int PG_TICKS_PER_MS = NS_PER_MS / PG_TICK_NS;
  localparam int PG_DELAY_MAX_TICKS = PG_DELAY_MAX_MS * PG_TICKS_PER_MS;

endpackage : pg_cfg_pkg

/* rtl/sync2.sv */
// Two-flop synchroniser for a vector of independent levels
`timescale 1ns/1ps
module sync2 #(
  parameter int WIDTH = 1
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic [WIDTH-1:0] async_i,
  output logic [WIDTH-1:0] sync_o
);
  // First stage, read only by the second stage
  logic [WIDTH-1:0] meta_r;

  // One chain per bit
  genvar b;
  generate
    for (b = 0; b < WIDTH; b++) begin : g_bit
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          meta_r[b] <= 1'b0;
          sync_o[b] <= 1'b0;
        end else begin
          meta_r[b] <= async_i[b];
          sync_o[b] <= meta_r[b];
        end
      end
    end
  endgenerate
endmodule // sync2

/* rtl/lin_to_ticks.sv */
// Converts a Linear-11 millisecond value into a saturated count of 125 ns ticks
`timescale 1ns/1ps
module lin_to_ticks
  import pg_cfg_pkg::*;
#(
  parameter logic [31:0] MAX_TICKS = 32'(PG_DELAY_MAX_TICKS)
) (
  input wire logic [15:0] lin_i,
  output logic [31:0] ticks_o
);
  // Scale factor sized to its use
  localparam logic [12:0] TPM = 13'(PG_TICKS_PER_MS);

  logic signed [LIN_EXP_W-1:0] exp_s; // Signed exponent N
  logic [LIN_MANT_W-1:0] mant; // Signed mantissa Y
  logic [63:0] prod; // Y times ticks per ms
  logic [63:0] shifted; // After the 2^N scaling

  always_comb begin
    exp_s = lin_i[LIN_EXP_LSB +: LIN_EXP_W];
    mant = lin_i[LIN_MANT_W-1:0];
    // Negative delays make no sense; treat them as zero
    if (mant[LIN_MANT_W-1]) begin
      prod = 64'h0;
    end else begin
      // Widen before the product; a 1 ms default needs 22 bits
      prod = 64'(mant[LIN_MANT_W-2:0]) * 64'(TPM);
    end
    if (exp_s < 0) begin
      shifted = prod >> (5'(-exp_s));
    end else begin
      shifted = prod << exp_s;
    end
    // Clip to the longest legal delay
    if (shifted > 64'(MAX_TICKS)) begin
      ticks_o = MAX_TICKS;
    end else begin
      ticks_o = shifted[31:0];
    end
  end
endmodule // lin_to_ticks

/* rtl/pg_delay_ramp_fault_config.sv */
// Power-ok delay, start-up ramp mode, fault capture mask and OV/UV qualification
`timescale 1ns/1ps
module pg_delay_ramp_fault_config
  import pg_cfg_pkg::*;
#(
  parameter int PAGES = 2,
  parameter logic [31:0] PG_DELAY_MAX_TICKS_P = 32'(PG_DELAY_MAX_TICKS)
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [$clog2(PAGES)-1:0] cmd_page_i,
  input wire logic [15:0] cmd_wdata_i,
  input wire logic [2:0] phases_in_rail_i,
  input wire logic pg_push_pull_i,
  input wire logic tick_clk_i,
  input wire logic [PAGES-1:0] above_pg_i,
  input wire logic [PAGES-1:0] ov_viol_i,
  input wire logic [PAGES-1:0] uv_viol_i,
  input wire logic [PAGES-1:0] enable_i,
  input wire logic [PAGES-1:0] pwm_high_i,
  input wire logic [PAGES-1:0] pwm_low_i,
  input wire logic [PAGES-1:0] soft_off_busy_i,
  input wire logic [15:0] fault_i,
  output logic [15:0] cmd_rdata_o,
  output logic cmd_rvalid_o,
  output logic cmd_nack_o,
  output logic [PAGES-1:0] output_ok_pin_o,
  output logic [PAGES-1:0] output_ok_pin_oe_o,
  output logic [PAGES-1:0] fast_loop_control_en_o,
  output logic multiphase_mode_o,
  output logic turnoff_fall_time_use_o,
  output logic [7:0] ramp_gain_o,
  output logic [11:0] ramp_slope_o,
  output logic [PAGES*16-1:0] inductance_o,
  output logic [PAGES-1:0] high_side_drive_o,
  output logic [PAGES-1:0] high_side_drive_oe_o,
  output logic [PAGES-1:0] low_side_drive_o,
  output logic [PAGES-1:0] ov_fault_o,
  output logic [PAGES-1:0] uv_fault_o,
  output logic capture_trigger_o
);

  // Width of the synchronised bundle: tick clock plus three per page
  localparam int SYNC_W = 1 + 3 * PAGES;

  // Global registers
  logic [7:0] ramp_gain_r; // Start-up ramp gain
  logic [15:0] cfm_r; // Capture fault mask

  // Paged registers
  logic [15:0] pgd_r [PAGES]; // Power-ok delay
  logic [15:0] ind_r [PAGES]; // Inductance setting
  logic [7:0] vfc_r [PAGES]; // Voltage fault config

  // Synchronised link-side levels
  logic [SYNC_W-1:0] sync_in;
  logic [SYNC_W-1:0] sync_out;
  logic tick_s; // Tick clock after two flops
  logic tick_d_r; // Previous tick level, edge finder
  logic tick_rise; // One cycle per 125 ns step
  logic [PAGES-1:0] above_s; // Output above threshold
  logic [PAGES-1:0] ov_s; // Overvoltage sample
  logic [PAGES-1:0] uv_s; // Undervoltage sample

  // Mode
  logic mp_mode; // Multiphase ramp mode

  // Per-page status
  logic [PAGES-1:0] good_r; // Power-ok after the delay
  logic [PAGES-1:0] ramp_done_r; // Start-up ramp has reached power-ok

  // Fault capture
  logic [15:0] fault_now; // External faults merged with own OV/UV
  logic [15:0] fault_d_r; // Previous fault levels
  logic [15:0] fault_new; // Unmasked rising faults

  // Bring link-side levels into the clock domain
  assign sync_in = {uv_viol_i, ov_viol_i, above_pg_i, tick_clk_i};

  sync2 #(
    .WIDTH(SYNC_W)
  ) u_sync (
    .ref_clk_i(ref_clk_i),
    .rst_i(rst_i),
    .async_i(sync_in),
    .sync_o(sync_out)
  );

  assign tick_s = sync_out[0];
  assign above_s = sync_out[PAGES:1];
  assign ov_s = sync_out[2*PAGES:PAGES+1];
  assign uv_s = sync_out[3*PAGES:2*PAGES+1];

  // Tick edge finder on the synchronised level
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      tick_d_r <= 1'b0;
    end else begin
      tick_d_r <= tick_s;
    end
  end

  assign tick_rise = tick_s & ~tick_d_r;

  // three or more phases means multiphase ramp
  assign mp_mode = (phases_in_rail_i >= PHASES_MULTI_MIN);

  // Global registers written over the command port
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ramp_gain_r <= RST_STARTUP_RAMP_GAIN;
      cfm_r <= RST_CAPTURE_FAULT_MASK;
    end else if (cmd_wr_i) begin
      // gain is one setting for all pages
      if (cmd_code_i == CODE_STARTUP_RAMP_GAIN) begin
        ramp_gain_r <= cmd_wdata_i[7:0];
      end
      if (cmd_code_i == CODE_CAPTURE_FAULT_MASK) begin
        cfm_r <= cmd_wdata_i & CFM_USED_BITS;
      end
    end
  end

  // Per-page logic
  genvar p;
  generate
    for (p = 0; p < PAGES; p++) begin : g_page
      logic wr_here; // Write aimed at this page
      logic [31:0] delay_ticks; // Programmed delay in ticks
      logic [31:0] cnt_r; // Elapsed delay ticks
      logic [VFC_COUNT_W-1:0] ov_cnt_r; // Consecutive OV violations
      logic [VFC_COUNT_W-1:0] uv_cnt_r; // Consecutive UV violations
      logic [VFC_COUNT_W-1:0] need; // N from the config

      assign wr_here = cmd_wr_i && (cmd_page_i == ($clog2(PAGES))'(p));
      assign need = vfc_r[p][VFC_COUNT_LSB +: VFC_COUNT_W];

      // Linear-11 milliseconds to 125 ns ticks
      lin_to_ticks #(
        .MAX_TICKS(PG_DELAY_MAX_TICKS_P)
      ) u_conv (
        .lin_i(pgd_r[p]),
        .ticks_o(delay_ticks)
      );

      // paged registers, one copy per page
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          pgd_r[p] <= RST_POWER_OK_DELAY;
          ind_r[p] <= RST_INDUCTANCE_SETTING;
          vfc_r[p] <= RST_VOLTAGE_FAULT_CONFIG;
        end else if (wr_here) begin
          if (cmd_code_i == CODE_POWER_OK_DELAY) begin
            pgd_r[p] <= cmd_wdata_i;
          end
          if (cmd_code_i == CODE_INDUCTANCE_SETTING) begin
            ind_r[p] <= cmd_wdata_i;
          end
          // bits 6:4 unused, kept at zero
          if (cmd_code_i == CODE_VOLTAGE_FAULT_CONFIG) begin
            vfc_r[p] <= cmd_wdata_i[7:0] & VFC_USED_BITS;
          end
        end
      end

      // Inductance is handed to the adaptive loop unchanged
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          inductance_o[p*16 +: 16] <= RST_INDUCTANCE_SETTING;
        end else begin
          inductance_o[p*16 +: 16] <= ind_r[p];
        end
      end

      // Power-ok delay timer
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          cnt_r <= 32'h0;
          good_r[p] <= 1'b0;
        end else if (!above_s[p] || !enable_i[p]) begin
          // drop below threshold restarts the delay
          cnt_r <= 32'h0;
          good_r[p] <= 1'b0;
        end else if (tick_rise && !good_r[p]) begin
          // assert only once the delay has run out
          if (cnt_r >= delay_ticks) begin
            good_r[p] <= 1'b1;
          end else begin
            cnt_r <= cnt_r + 32'h1;
          end
        end
      end

      // Pin driver; glitch-free since both come from flops
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          output_ok_pin_o[p] <= 1'b0;
          output_ok_pin_oe_o[p] <= 1'b1;
        end else if (pg_push_pull_i) begin
          output_ok_pin_o[p] <= good_r[p];
          output_ok_pin_oe_o[p] <= 1'b1;
        end else begin
          // open-drain pulls low only when not good
          output_ok_pin_o[p] <= 1'b0;
          output_ok_pin_oe_o[p] <= ~good_r[p];
        end
      end

      // Start-up ramp tracker for the fast loop
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          ramp_done_r[p] <= 1'b0;
        end else if (!enable_i[p]) begin
          // Next turn-on is a fresh ramp
          ramp_done_r[p] <= 1'b0;
        end else if (good_r[p]) begin
          ramp_done_r[p] <= 1'b1;
        end
      end

      // Fast loop enable
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          fast_loop_control_en_o[p] <= 1'b1;
        end else if (!mp_mode) begin
          // standalone keeps the fast loop on
          fast_loop_control_en_o[p] <= 1'b1;
        end else begin
          fast_loop_control_en_o[p] <= ramp_done_r[p];
        end
      end

      // Consecutive violation counters, sampled once per tick
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          ov_cnt_r <= '0;
          ov_fault_o[p] <= 1'b0;
        end else if (tick_rise) begin
          if (!ov_s[p]) begin
            ov_cnt_r <= '0;
          end else if (ov_cnt_r == need) begin
            ov_fault_o[p] <= 1'b1;
          end else begin
            ov_cnt_r <= ov_cnt_r + 1'b1;
          end
        end else if (!enable_i[p]) begin
          // Fault clears on restart; a tick in the same cycle wins
          ov_fault_o[p] <= 1'b0;
        end
      end

      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          uv_cnt_r <= '0;
          uv_fault_o[p] <= 1'b0;
        end else if (tick_rise) begin
          if (!uv_s[p]) begin
            uv_cnt_r <= '0;
          end else if (uv_cnt_r == need) begin
            uv_fault_o[p] <= 1'b1;
          end else begin
            uv_cnt_r <= uv_cnt_r + 1'b1;
          end
        end else if (!enable_i[p]) begin
          uv_fault_o[p] <= 1'b0;
        end
      end

      // Power stage drive states
      always_ff @(posedge ref_clk_i) begin
        if (rst_i) begin
          high_side_drive_o[p] <= 1'b0;
          high_side_drive_oe_o[p] <= 1'b0;
          low_side_drive_o[p] <= 1'b0;
        end else if (ov_fault_o[p]) begin
          // OV shutdown low side from bit seven
          high_side_drive_o[p] <= 1'b0;
          high_side_drive_oe_o[p] <= 1'b0;
          low_side_drive_o[p] <= vfc_r[p][VFC_LOW_SIDE_BIT];
        end else if (enable_i[p]) begin
          // Normal switching
          high_side_drive_o[p] <= pwm_high_i[p];
          high_side_drive_oe_o[p] <= 1'b1;
          low_side_drive_o[p] <= pwm_low_i[p];
        end else if (!mp_mode && soft_off_busy_i[p]) begin
          high_side_drive_o[p] <= pwm_high_i[p];
          high_side_drive_oe_o[p] <= 1'b1;
          low_side_drive_o[p] <= pwm_low_i[p];
        end else begin
          // high side tri-state, low side low
          high_side_drive_o[p] <= 1'b0;
          high_side_drive_oe_o[p] <= 1'b0;
          low_side_drive_o[p] <= 1'b0;
        end
      end
    end
  endgenerate

  // Mode outputs for the ramp generator
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      multiphase_mode_o <= 1'b0;
      turnoff_fall_time_use_o <= 1'b1;
    end else begin
      multiphase_mode_o <= mp_mode;
      // fall time ignored in multiphase mode
      turnoff_fall_time_use_o <= ~mp_mode;
    end
  end

  // Ramp slope; the ramp generator multiplies by Vin and fsw
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      ramp_gain_o <= RST_STARTUP_RAMP_GAIN;
      ramp_slope_o <= 12'(RST_STARTUP_RAMP_GAIN) * 12'(RAMP_SLOPE_FACTOR);
    end else begin
      ramp_gain_o <= ramp_gain_r;
      // slope is 14 times gain, smaller gain slower
      // Widened first, a byte product would wrap above gain 18
      ramp_slope_o <= 12'(ramp_gain_r) * 12'(RAMP_SLOPE_FACTOR);
    end
  end

  // Merge own OV/UV faults into the external fault vector
  always_comb begin
    fault_now = fault_i & CFM_USED_BITS;
    fault_now[CFM_OUT_OV_BIT] = fault_i[CFM_OUT_OV_BIT] | (|ov_fault_o);
    fault_now[CFM_OUT_UV_BIT] = fault_i[CFM_OUT_UV_BIT] | (|uv_fault_o);
  end

  // each bit names one fault, masked individually
  assign fault_new = fault_now & ~fault_d_r & ~cfm_r;

  // Capture trigger fires once per cycle in which any unmasked fault rises
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      fault_d_r <= 16'h0000;
      capture_trigger_o <= 1'b0;
    end else begin
      fault_d_r <= fault_now;
      capture_trigger_o <= |fault_new;
    end
  end

  // Read back and refusal of unknown codes
  always_ff @(posedge ref_clk_i) begin
    if (rst_i) begin
      cmd_rdata_o <= 16'h0000;
      cmd_rvalid_o <= 1'b0;
      cmd_nack_o <= 1'b0;
    end else begin
      cmd_rvalid_o <= 1'b0;
      cmd_nack_o <= 1'b0;
      if (cmd_rd_i) begin
        cmd_rvalid_o <= 1'b1;
        case (cmd_code_i)
          CODE_POWER_OK_DELAY: cmd_rdata_o <= pgd_r[cmd_page_i];
          CODE_STARTUP_RAMP_GAIN: cmd_rdata_o <= {8'h00, ramp_gain_r};
          CODE_INDUCTANCE_SETTING: cmd_rdata_o <= ind_r[cmd_page_i];
          CODE_CAPTURE_FAULT_MASK: cmd_rdata_o <= cfm_r;
          CODE_VOLTAGE_FAULT_CONFIG: cmd_rdata_o <= {8'h00, vfc_r[cmd_page_i]};
          default: begin
            // Not ours: answer zero and refuse
            cmd_rdata_o <= 16'h0000;
            cmd_rvalid_o <= 1'b0;
            cmd_nack_o <= 1'b1;
          end
        endcase
      end else if (cmd_wr_i) begin
        // Writes to unknown codes are refused too
        if (cmd_code_i < CODE_POWER_OK_DELAY || cmd_code_i > CODE_VOLTAGE_FAULT_CONFIG) begin
          cmd_nack_o <= 1'b1;
        end
      end
    end
  end

endmodule // pg_delay_ramp_fault_config

/* verif/pg_cfg_assertions.sv */
// Port checker of the command, ramp mode, drive and output-ok behaviour
`timescale 1ns/1ps
module pg_cfg_assertions
  import pg_cfg_pkg::*;
#(
  parameter int PAGES = 2
) (
  input wire logic ref_clk_i,
  input wire logic rst_i,
  input wire logic cmd_wr_i,
  input wire logic cmd_rd_i,
  input wire logic [7:0] cmd_code_i,
  input wire logic [2:0] phases_in_rail_i,
  input wire logic pg_push_pull_i,
  input wire logic [PAGES-1:0] enable_i,
  input wire logic cmd_rvalid_o,
  input wire logic cmd_nack_o,
  input wire logic [PAGES-1:0] output_ok_pin_o,
  input wire logic [PAGES-1:0] output_ok_pin_oe_o,
  input wire logic [PAGES-1:0] fast_loop_control_en_o,
  input wire logic multiphase_mode_o,
  input wire logic turnoff_fall_time_use_o,
  input wire logic [7:0] ramp_gain_o,
  input wire logic [11:0] ramp_slope_o,
  input wire logic [PAGES-1:0] high_side_drive_oe_o,
  input wire logic [PAGES-1:0] low_side_drive_o,
  input wire logic [PAGES-1:0] ov_fault_o
);
  default clocking @(posedge ref_clk_i); endclocking
  default disable iff (rst_i);
  // Code inside the mapped window
  logic known;
  assign known = cmd_code_i >= CODE_POWER_OK_DELAY && cmd_code_i <= CODE_VOLTAGE_FAULT_CONFIG;
  // Slope register updates on the same edge as the gain
  sequence s_gain_held;
    $stable(ramp_gain_o) [*2];
  endsequence
  // Mode flags need a few cycles to settle after a phase change
  sequence s_standalone;
    (phases_in_rail_i < PHASES_MULTI_MIN) [*4];
  endsequence
  a_read_valid: assert property (cmd_rd_i && known |=> cmd_rvalid_o && !cmd_nack_o)
    else $error("mapped read gave no data strobe");
  a_unknown_nack: assert property ((cmd_rd_i || cmd_wr_i) && !known |=> cmd_nack_o && !cmd_rvalid_o)
    else $error("unknown code not refused");
  a_rvalid_cause: assert property (cmd_rvalid_o |-> $past(cmd_rd_i))
    else $error("data strobe without a read");
  a_slope_follow: assert property (s_gain_held |-> ramp_slope_o == 12'(ramp_gain_o) * 12'hE)
    else $error("ramp slope differs from gain times fourteen");
  a_standalone_fast: assert property (s_standalone |-> &fast_loop_control_en_o && !multiphase_mode_o)
    else $error("fast loop off in standalone mode");
  a_fall_ignored: assert property ((phases_in_rail_i >= PHASES_MULTI_MIN) [*2] |->
    multiphase_mode_o && !turnoff_fall_time_use_o)
    else $error("fall time used in multiphase mode");
  a_multi_shutdown: assert property (multiphase_mode_o && !enable_i[0] && !ov_fault_o[0] |=>
    !high_side_drive_oe_o[0] && !low_side_drive_o[0])
    else $error("multiphase shutdown left a drive on");
  a_ok_idle: assert property (!enable_i[0] [*4] |-> output_ok_pin_oe_o[0] && !output_ok_pin_o[0])
    else $error("output-ok asserted while disabled");
  a_open_drain: assert property (!pg_push_pull_i [*2] |-> !output_ok_pin_o[0])
    else $error("open-drain output-ok driven high");
endmodule // pg_cfg_assertions

bind pg_delay_ramp_fault_config pg_cfg_assertions #(.PAGES(PAGES)) i_chk (.ref_clk_i, .rst_i, .cmd_wr_i,
  .cmd_rd_i, .cmd_code_i, .phases_in_rail_i, .pg_push_pull_i, .enable_i, .cmd_rvalid_o, .cmd_nack_o,
  .output_ok_pin_o, .output_ok_pin_oe_o, .fast_loop_control_en_o, .multiphase_mode_o,
  .turnoff_fall_time_use_o, .ramp_gain_o, .ramp_slope_o, .high_side_drive_oe_o, .low_side_drive_o,
  .ov_fault_o);

/* verif/pg_stage_model.sv */
// Power stage side: free-running tick and sensed output levels
`timescale 1ns/1ps
module pg_stage_model (
  input wire logic [1:0] above_req_i,
  input wire logic [1:0] ov_req_i,
  input wire logic [1:0] uv_req_i,
  output logic tick_clk_o,
  output logic [1:0] above_o,
  output logic [1:0] ov_o,
  output logic [1:0] uv_o
);
  // Tick of 125 ns, phase unrelated to the core clock
  initial begin
    tick_clk_o = 1'b0;
    above_o = 2'h0;
    ov_o = 2'h0;
    uv_o = 2'h0;
    #3.3;
    forever #62.5 tick_clk_o = ~tick_clk_o;
  end
  // Levels move on the falling tick so every sample sees a settled value
  always @(negedge tick_clk_o) begin
    above_o <= above_req_i;
    ov_o <= ov_req_i;
    uv_o <= uv_req_i;
  end
endmodule // pg_stage_model

/* verif/testbench.sv */
// Self-checking bench of the power-ok, ramp mode and fault configuration block
`timescale 1ns/1ps
`define CHK(n, e, g) begin n_tests++; if ((g) !== (e)) begin error_cnt++; $display("BAD %s exp %0h got %0h", n, e, g); end end
module testbench;
  import pg_cfg_pkg::*;
  // Core side stimulus
  logic ref_clk_i = 0;
  logic rst_i = 1;
  logic cmd_wr_i = 0;
  logic cmd_rd_i = 0;
  logic cmd_page_i = 0;
  logic pg_push_pull_i = 1;
  logic [7:0] cmd_code_i = 8'hD4;
  logic [15:0] cmd_wdata_i = 16'h0000;
  logic [15:0] fault_i = 16'h0000;
  logic [2:0] phases_in_rail_i = 3'h1;
  logic [1:0] enable_i = 0, pwm_high_i = 0, pwm_low_i = 0, soft_off_busy_i = 0;
  // Requests to the power stage model
  logic [1:0] above_req = 0, ov_req = 0, uv_req = 0;
  logic [1:0] above_pg_i, ov_viol_i, uv_viol_i, ok, ok_oe, fl_en, hs, hs_oe, ls, ovf, uvf;
  logic tick_clk_i, cmd_rvalid_o, cmd_nack_o, mp, fall_use, cap;
  logic [15:0] cmd_rdata_o;
  logic [7:0] ramp_gain_o;
  logic [11:0] ramp_slope_o;
  logic [31:0] ind;
  // Reference register file; global codes live in page 0
  logic [15:0] m [5][2];
  int error_cnt = 0;
  int n_tests = 0;
  int seed = 32'h2317;
  int caps = 0;
  int c, n;

  // Clip limit kept small so the default delay stays short
  pg_delay_ramp_fault_config #(.PAGES(2), .PG_DELAY_MAX_TICKS_P(32'h82)) i_dut (.ref_clk_i, .rst_i,
    .cmd_wr_i, .cmd_rd_i, .cmd_code_i, .cmd_page_i, .cmd_wdata_i, .phases_in_rail_i, .pg_push_pull_i,
    .tick_clk_i, .above_pg_i, .ov_viol_i, .uv_viol_i, .enable_i, .pwm_high_i, .pwm_low_i,
    .soft_off_busy_i, .fault_i, .cmd_rdata_o, .cmd_rvalid_o, .cmd_nack_o, .output_ok_pin_o(ok),
    .output_ok_pin_oe_o(ok_oe), .fast_loop_control_en_o(fl_en), .multiphase_mode_o(mp),
    .turnoff_fall_time_use_o(fall_use), .ramp_gain_o, .ramp_slope_o, .inductance_o(ind),
    .high_side_drive_o(hs), .high_side_drive_oe_o(hs_oe), .low_side_drive_o(ls), .ov_fault_o(ovf),
    .uv_fault_o(uvf), .capture_trigger_o(cap));
  pg_stage_model i_stage (.above_req_i(above_req), .ov_req_i(ov_req), .uv_req_i(uv_req),
    .tick_clk_o(tick_clk_i), .above_o(above_pg_i), .ov_o(ov_viol_i), .uv_o(uv_viol_i));

  initial forever #4 ref_clk_i = ~ref_clk_i;
  // Capture pulses are one cycle, so count each sampled high
  always @(posedge ref_clk_i) if (cap === 1'b1) caps++;

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_tests, error_cnt);
    if (error_cnt == 0 && n_tests > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task automatic cyc(input int k);
    repeat (k) @(posedge ref_clk_i);
  endtask
  // Bounded wait for k rising ticks, returning just after the last
  task automatic ticks(input int k);
    int w;
    repeat (k) begin
      w = 0;
      while (tick_clk_i !== 1'b0 && w < 40) begin
        @(posedge ref_clk_i);
        w++;
      end
      while (tick_clk_i !== 1'b1 && w < 80) begin
        @(posedge ref_clk_i);
        w++;
      end
      if (w >= 80) begin
        $display("BAD tick wait exp 1 got 0");
        error_cnt++;
        end_sim();
      end
    end
  endtask
  // One strobe; the answer is read one cycle after the taking edge
  task automatic cmd(input logic wr, input logic [7:0] code, input logic p, input logic [15:0] d);
    @(posedge ref_clk_i);
    cmd_wr_i <= wr;
    cmd_rd_i <= !wr;
    cmd_code_i <= code;
    cmd_page_i <= p;
    cmd_wdata_i <= d;
    @(posedge ref_clk_i);
    cmd_wr_i <= 1'b0;
    cmd_rd_i <= 1'b0;
    @(posedge ref_clk_i);
  endtask
  // Write through the port and into the model, unused bits dropped
  task automatic wr(input int k, input logic p, input logic [15:0] d);
    cmd(1'b1, 8'hD4 + 8'(k), p, d);
    m[k][(k == 1 || k == 3) ? 0 : p] = k == 1 ? d & 16'h00FF : k == 3 ? d & CFM_USED_BITS :
      k == 4 ? d & {8'h00, VFC_USED_BITS} : d;
  endtask
  task automatic rd_chk(input int k, input logic p);
    cmd(1'b0, 8'hD4 + 8'(k), p, 16'h0000);
    `CHK("rdata", m[k][(k == 1 || k == 3) ? 0 : p], cmd_rdata_o)
    `CHK("rvalid", 1'b1, cmd_rvalid_o)
  endtask
  task automatic out_chk;
    `CHK("gain", m[1][0][7:0], ramp_gain_o)
    `CHK("slope", 12'(m[1][0][7:0]) * 12'hE, ramp_slope_o)
    `CHK("ind0", m[2][0], ind[15:0])
    `CHK("ind1", m[2][1], ind[31:16])
  endtask
  // Power-ok delay of d ticks on page 0, optionally broken off halfway
  task automatic pg_run(input int d, input logic drop);
    logic multi;
    multi = phases_in_rail_i >= PHASES_MULTI_MIN;
    ticks(1);
    enable_i[0] <= 1'b1;
    above_req[0] <= 1'b1;
    if (drop) begin
      ticks(d / 2);
      above_req[0] <= 1'b0;
      ticks(2);
      above_req[0] <= 1'b1;
    end
    ticks(d);
    cyc(8);
    `CHK("ok_off", 2'b01, {ok[0], ok_oe[0]})
    `CHK("fast_ramp", !multi, fl_en[0])
    `CHK("multi", multi, mp)
    `CHK("fall_use", !multi, fall_use)
    ticks(1);
    cyc(8);
    `CHK("ok_oe", pg_push_pull_i, ok_oe[0])
    `CHK("ok_on", 1'b1, ok[0] | ~pg_push_pull_i)
    `CHK("fast_on", 1'b1, fl_en[0])
    // Shutdown with soft-off requested: only standalone lets it through
    pwm_high_i <= 2'($random(seed));
    pwm_low_i <= 2'($random(seed));
    soft_off_busy_i <= 2'b11;
    enable_i[0] <= 1'b0;
    cyc(3);
    `CHK("hs", multi ? 1'b0 : pwm_high_i[0], multi ? hs_oe[0] : hs[0])
    `CHK("ls", multi ? 1'b0 : pwm_low_i[0], ls[0])
    soft_off_busy_i <= 2'b00;
    above_req[0] <= 1'b0;
    ticks(2);
    $display("power-ok pass of %0d ticks done", d);
  endtask

  initial begin
    for (int p = 0; p < 2; p++) begin
      m[0][p] = RST_POWER_OK_DELAY;
      m[1][p] = {8'h00, RST_STARTUP_RAMP_GAIN};
      m[2][p] = RST_INDUCTANCE_SETTING;
      m[3][p] = RST_CAPTURE_FAULT_MASK;
      m[4][p] = {8'h00, RST_VOLTAGE_FAULT_CONFIG};
    end
    cyc(8);
    rst_i <= 1'b0;
    for (c = 0; c < 5; c++) begin
      rd_chk(c, 1'b0);
      rd_chk(c, 1'b1);
    end
    out_chk();
    // Unmapped codes: refused, nothing changes
    cmd(1'b0, 8'hD9, 1'b0, 16'h0000);
    `CHK("nack_rd", 2'b10, {cmd_nack_o, cmd_rvalid_o})
    `CHK("rdata_bad", 16'h0000, cmd_rdata_o)
    cmd(1'b1, 8'hD3, 1'b0, 16'hFFFF);
    `CHK("nack_wr", 1'b1, cmd_nack_o)
    rd_chk(0, 1'b0);
    $display("reset and map test done");
    // Default 1 ms is clipped to the bench limit
    pg_run(130, 1'b0);
    phases_in_rail_i <= 3'h3;
    wr(0, 1'b0, 16'hD001);
    pg_run(125, 1'b1);
    phases_in_rail_i <= 3'h1;
    pg_push_pull_i <= 1'b0;
    wr(0, 1'b0, 16'h07FF);
    pg_run(0, 1'b0);
    pg_push_pull_i <= 1'b1;
    for (int i = 0; i < 24; i++) begin
      c = ($random(seed) & 32'h7FFF) % 5;
      wr(c, 1'($random(seed)), 16'($random(seed)));
      rd_chk(c, 1'b0);
      rd_chk(c, 1'b1);
    end
    out_chk();
    $display("random register test done");
    // Qualification count N, low side on at OV, UV and OT masked
    n = $random(seed) & 32'hF;
    wr(4, 1'b0, 16'h0080 | 16'(n));
    wr(3, 1'b0, 16'h0006);
    enable_i[0] <= 1'b1;
    caps = 0;
    // Set after a falling tick, so first seen two rising ticks on
    ticks(1);
    cyc(8);
    ov_req[0] <= 1'b1;
    uv_req[0] <= 1'b1;
    ticks(n + 1);
    // Dropped before this tick falls: next sample is good
    ov_req[0] <= 1'b0;
    cyc(8);
    `CHK("ovuv_early", 2'b00, {ovf[0], uvf[0]})
    ticks(1);
    cyc(8);
    `CHK("uv_only", 2'b01, {ovf[0], uvf[0]})
    ov_req[0] <= 1'b1;
    ticks(n + 1);
    cyc(8);
    `CHK("ov_early", 1'b0, ovf[0])
    ticks(1);
    cyc(8);
    `CHK("ov", 1'b1, ovf[0])
    `CHK("ls_ov", 1'b1, ls[0])
    fault_i <= 16'h0004;
    cyc(3);
    fault_i <= 16'h000C;
    cyc(3);
    `CHK("captures", 2, caps)
    enable_i[0] <= 1'b0;
    ov_req[0] <= 1'b0;
    uv_req[0] <= 1'b0;
    fault_i <= 16'h0000;
    cyc(4);
    $display("fault test done");
    end_sim();
  end
endmodule // testbench
